// ### rtl/hul_pkg.sv
package hul_pkg;
  // clock and rates
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int ACC_W = 16;
  localparam longint BAUD_125K = 125_000;
  localparam longint BAUD_250K = 250_000;
  localparam longint BAUD_500K = 500_000;
  localparam longint BAUD_1M = 1_000_000;
  // baud field codes
  localparam logic [1:0] BAUD_CODE_125K = 2'h0;
  localparam logic [1:0] BAUD_CODE_250K = 2'h1;
  localparam logic [1:0] BAUD_CODE_500K = 2'h2;
  localparam logic [1:0] BAUD_CODE_1M = 2'h3;
  // line timing, bit periods and microseconds
  localparam int BRK_MIN_BITS = 12;
  localparam int BRK_TICKS = BRK_MIN_BITS * OVERSAMPLE;
  localparam int T_RST_US = 100;
  localparam int RST_CYCLES = T_RST_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // register addresses
  localparam logic [3:0] ADDR_LINK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_HOLDOFF = 4'h1;
  localparam logic [3:0] ADDR_SER_FAULT = 4'h2;
  localparam logic [3:0] ADDR_XFER_FAULT = 4'h3;
  localparam logic [3:0] ADDR_LINK_STAT = 4'h4;
  // reset values
  localparam logic [7:0] HOLDOFF_RST = 8'h01;
  localparam logic TXEN_RST = 1'b1;
  localparam logic MDROP_RST = 1'b0;

  typedef struct packed {
    logic shared_bus_mode;
    logic transmitter_enable;
    logic [1:0] baud;
  } hul_ctrl_s;

  typedef struct packed {
    logic link_reset_detected;
    logic clear_detected;
    logic stop_err;
  } hul_fault_s;

  typedef struct packed {
    logic sof_err;
    logic wait_err;
  } hul_xfer_s;

  typedef enum logic [1:0] {
    HUL_IDLE = 2'b00,
    HUL_START = 2'b01,
    HUL_DATA = 2'b11,
    HUL_STOP = 2'b10
  } hul_state_e;

  // phase step giving sixteen ticks per bit at the chosen rate
  function automatic logic [ACC_W-1:0] inc_of(input logic [1:0] code);
    longint rate;
    rate = BAUD_1M;
    unique case (code)
      BAUD_CODE_125K: rate = BAUD_125K;
      BAUD_CODE_250K: rate = BAUD_250K;
      BAUD_CODE_500K: rate = BAUD_500K;
      BAUD_CODE_1M: rate = BAUD_1M;
    endcase
    return ACC_W'((rate * OVERSAMPLE * (64'd1 << ACC_W)) / CLK_HZ);
  endfunction : inc_of
endpackage : hul_pkg

// ### rtl/hul_uart_link.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module hul_uart_link #(
  parameter int RST_CYC = hul_pkg::RST_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // serial link
  input wire logic i_rx,
  output logic o_tx,
  // receive stream
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_sof,
  // transmit stream
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // frame layer and device status
  input wire logic i_frame_ok,
  input wire logic i_resp_pending,
  input wire logic i_sleep_mode,
  input wire logic [1:0] i_otp_baud,
  output logic o_resp_abort
);
  import hul_pkg::*;

  logic rst_meta_ff, rst_n_ff;
  logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
  logic otp_done_ff;
  hul_ctrl_s ctrl_ff;
  logic [7:0] holdoff_ff;
  logic [1:0] baud_act_ff;
  hul_fault_s fault_ff;
  hul_xfer_s xfer_ff;
  logic [7:0] rdata_ff;
  logic [ACC_W-1:0] acc_ff;
  hul_state_e rx_st_ff, tx_st_ff;
  logic [3:0] rx_sub_ff, tx_sub_ff;
  logic [2:0] rx_bit_ff, tx_bit_ff;
  logic [7:0] rx_sh_ff, tx_sh_ff;
  logic [7:0] rx_data_ff;
  logic rx_valid_ff, sof_ff, tx_ff, abort_ff;
  logic [CNT_W-1:0] brk_cnt_ff, rst_cnt_ff;
  logic [3:0] hold_sub_ff;
  logic [7:0] hold_cnt_ff;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= i_rx;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  wire [ACC_W:0] acc_sum = {1'b0, acc_ff} + {1'b0, inc_of(baud_act_ff)};
  wire tick = acc_sum[ACC_W];
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) acc_ff <= '0;
    else acc_ff <= acc_sum[ACC_W-1:0];
  end

  // line low timers for clear and reset
  wire rx_low = !rx_sync_ff;
  wire brk_hit = rx_low && tick && (brk_cnt_ff == CNT_W'(BRK_TICKS - 1));
  wire rst_hit = rx_low && (rst_cnt_ff == CNT_W'(RST_CYC - 1));
  // reset also counts as a clear
  wire clr_evt = brk_hit || rst_hit;
  wire tx_busy = (tx_st_ff != HUL_IDLE);
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      brk_cnt_ff <= '0;
      rst_cnt_ff <= '0;
    end else begin
      // count low ticks for clear, sixteen per bit period, and low clock cycles for reset
      if (!rx_low) brk_cnt_ff <= '0;
      else if (tick && brk_cnt_ff != CNT_W'(BRK_TICKS)) brk_cnt_ff <= brk_cnt_ff + 1'b1;
      if (!rx_low) rst_cnt_ff <= '0;
      else if (rst_cnt_ff != CNT_W'(RST_CYC)) rst_cnt_ff <= rst_cnt_ff + 1'b1;
    end
  end

  // register decode
  wire wr_ctrl = i_wr && (i_addr == ADDR_LINK_CTRL);
  wire wr_hold = i_wr && (i_addr == ADDR_HOLDOFF);
  wire wr_flt = i_wr && (i_addr == ADDR_SER_FAULT);
  wire wr_xfr = i_wr && (i_addr == ADDR_XFER_FAULT);

  // receiver sample points
  wire rx_mid = tick && (rx_sub_ff == 4'h7);
  wire rx_end = tick && (rx_sub_ff == 4'hF);
  wire stop_done = (rx_st_ff == HUL_STOP) && rx_end;
  wire stop_bad = stop_done && rx_low;
  wire rx_begin = (rx_st_ff == HUL_IDLE) && rx_low && rx_prev_ff && !tx_busy;

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_st_ff <= HUL_IDLE;
      rx_sub_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
    end else if (clr_evt) begin
      rx_st_ff <= HUL_IDLE;
    end else begin
      if (tick) rx_sub_ff <= rx_sub_ff + 1'b1;
      unique case (rx_st_ff)
        HUL_IDLE: begin
          rx_sub_ff <= '0;
          if (rx_begin) rx_st_ff <= HUL_START;
        end
        HUL_START: begin
          if (rx_mid) begin
            rx_sub_ff <= '0;
            rx_bit_ff <= '0;
            rx_st_ff <= rx_low ? HUL_DATA : HUL_IDLE;
          end
        end
        HUL_DATA: begin
          if (rx_end) begin
            rx_sh_ff <= {rx_sync_ff, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == 3'h7) rx_st_ff <= HUL_STOP;
          end
        end
        HUL_STOP: begin
          if (rx_end) rx_st_ff <= HUL_IDLE;
        end
      endcase
    end
  end

  // received byte and start-of-frame mark
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      sof_ff <= 1'b0;
    end else begin
      rx_valid_ff <= stop_done && !stop_bad && !clr_evt;
      if (stop_done && !stop_bad) rx_data_ff <= rx_sh_ff;
      // next byte is start of frame
      sof_ff <= clr_evt;
    end
  end

  // hold-off counted in bit periods after last rx bit
  wire hold_bit = tick && (hold_sub_ff == 4'hF);
  wire hold_done = (hold_cnt_ff >= holdoff_ff);
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hold_sub_ff <= '0;
      hold_cnt_ff <= '0;
    end else if (rx_st_ff != HUL_IDLE) begin
      hold_sub_ff <= '0;
      hold_cnt_ff <= '0;
    end else begin
      if (tick) hold_sub_ff <= hold_sub_ff + 1'b1;
      if (hold_bit && hold_cnt_ff != 8'hFF) hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end
  end

  // ready only after hold-off and with transmitter enabled
  assign o_tx_ready = (tx_st_ff == HUL_IDLE) && hold_done && ctrl_ff.transmitter_enable
                      && (rx_st_ff == HUL_IDLE) && !clr_evt && rx_sync_ff;
  wire tx_take = o_tx_ready && i_tx_valid;
  wire tx_bit = tick && (tx_sub_ff == 4'hF);
  // disable or clear/reset aborts at once
  wire tx_kill = !ctrl_ff.transmitter_enable || clr_evt;

  // transmitter
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_st_ff <= HUL_IDLE;
      tx_sub_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_ff <= 1'b1;
    end else if (tx_kill) begin
      tx_st_ff <= HUL_IDLE;
      tx_ff <= 1'b1;
    end else begin
      if (tick) tx_sub_ff <= tx_sub_ff + 1'b1;
      unique case (tx_st_ff)
        HUL_IDLE: begin
          tx_sub_ff <= '0;
          tx_ff <= 1'b1;
          if (tx_take) begin
            tx_sh_ff <= i_tx_data;
            tx_ff <= 1'b0;
            tx_st_ff <= HUL_START;
          end
        end
        HUL_START: begin
          if (tx_bit) begin
            tx_ff <= tx_sh_ff[0];
            tx_bit_ff <= '0;
            tx_st_ff <= HUL_DATA;
          end
        end
        HUL_DATA: begin
          if (tx_bit) begin
            tx_bit_ff <= tx_bit_ff + 1'b1;
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            tx_ff <= (tx_bit_ff == 3'h7) ? 1'b1 : tx_sh_ff[1];
            if (tx_bit_ff == 3'h7) tx_st_ff <= HUL_STOP;
          end
        end
        HUL_STOP: begin
          if (tx_bit) tx_st_ff <= HUL_IDLE;
        end
      endcase
    end
  end

  // control registers, OTP baud caught after reset release
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      otp_done_ff <= 1'b0;
      ctrl_ff <= '{shared_bus_mode: MDROP_RST, transmitter_enable: TXEN_RST, baud: BAUD_CODE_1M};
      holdoff_ff <= HOLDOFF_RST;
      baud_act_ff <= BAUD_CODE_1M;
    end else begin
      otp_done_ff <= 1'b1;
      if (wr_ctrl) ctrl_ff <= hul_ctrl_s'(i_wdata[3:0]);
      if (wr_hold) holdoff_ff <= i_wdata;
      if (!otp_done_ff) begin
        ctrl_ff.baud <= i_otp_baud;
        baud_act_ff <= i_otp_baud;
      end else if (rst_hit) begin
        baud_act_ff <= BAUD_CODE_250K;
      end else if (i_frame_ok) begin
        // commit after valid frame, code picks rate
        baud_act_ff <= wr_ctrl ? i_wdata[1:0] : ctrl_ff.baud;
      end
    end
  end

  // fault flag sources
  // break clear sets stop, not in sleep; link reset sets it always
  wire set_stop = ((stop_bad || brk_hit) && !i_sleep_mode) || rst_hit;
  wire pend = i_resp_pending || tx_busy;
  wire set_wait = clr_evt && pend && (ctrl_ff.shared_bus_mode || !tx_busy);
  // daisy clear during sending gives sof error
  wire set_sof = clr_evt && tx_busy && !ctrl_ff.shared_bus_mode;
  wire [2:0] flt_set = {rst_hit, clr_evt, set_stop};
  wire [1:0] xfr_set = {set_sof, set_wait};
  wire [2:0] flt_clr = wr_flt ? i_wdata[2:0] : 3'h0;
  wire [1:0] xfr_clr = wr_xfr ? i_wdata[1:0] : 2'h0;

  // write-one-clear, set wins
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fault_ff <= '0;
      xfer_ff <= '0;
      abort_ff <= 1'b0;
    end else begin
      fault_ff <= (fault_ff & ~flt_clr) | flt_set;
      xfer_ff <= (xfer_ff & ~xfr_clr) | xfr_set;
      abort_ff <= clr_evt && pend;
    end
  end

  wire [7:0] rd_mux = (i_addr == ADDR_LINK_CTRL) ? {4'h0, ctrl_ff} :
                      (i_addr == ADDR_HOLDOFF) ? holdoff_ff :
                      (i_addr == ADDR_SER_FAULT) ? {5'h00, fault_ff} :
                      (i_addr == ADDR_XFER_FAULT) ? {6'h00, xfer_ff} :
                      (i_addr == ADDR_LINK_STAT) ? {6'h00, baud_act_ff} : 8'h00;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) rdata_ff <= '0;
    else if (i_rd) rdata_ff <= rd_mux;
  end

  assign o_rdata = rdata_ff;
  assign o_tx = tx_ff;
  assign o_rx_data = rx_data_ff;
  assign o_rx_valid = rx_valid_ff;
  assign o_rx_sof = sof_ff;
  assign o_resp_abort = abort_ff;

  // checks
  AST_STOP_FLAG: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    stop_bad && !i_sleep_mode |=> fault_ff.stop_err) else $error("stop error not flagged");
  AST_BRK_CLEAR: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    brk_hit |=> fault_ff.clear_detected && o_rx_sof && rx_st_ff == HUL_IDLE) else $error("clear not acted on");
  AST_BRK_STOP: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    brk_hit && !i_sleep_mode |=> fault_ff.stop_err) else $error("clear without stop error");
  AST_SLEEP_CLR: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    brk_hit && i_sleep_mode && !rst_hit && !fault_ff.stop_err |=> fault_ff.clear_detected && !fault_ff.stop_err)
    else $error("stop error set in sleep");
  AST_TX_OFF: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    !ctrl_ff.transmitter_enable |=> o_tx && !tx_busy) else $error("tx active while disabled");
  AST_RST_BAUD: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    rst_hit && otp_done_ff |=> baud_act_ff == BAUD_CODE_250K && fault_ff.link_reset_detected
    && $stable(ctrl_ff.baud)) else $error("reset baud not 250k");
  AST_HALF_DUPLEX: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    tx_busy && rx_st_ff == HUL_IDLE |=> rx_st_ff == HUL_IDLE) else $error("rx started during tx");
  AST_HOLDOFF: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    tx_take |-> hold_cnt_ff >= holdoff_ff) else $error("tx before hold-off");
  AST_ABORT_TX: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    clr_evt && tx_busy |=> !tx_busy ##1 o_tx) else $error("tx not aborted");
  AST_MDROP_WAIT: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    clr_evt && ctrl_ff.shared_bus_mode && pend |=> xfer_ff.wait_err && o_resp_abort)
    else $error("multidrop wait error missing");
  AST_STATUS: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
    i_rd && i_addr == ADDR_LINK_STAT |=> o_rdata[1:0] == $past(baud_act_ff)) else $error("baud status wrong");
endmodule : hul_uart_link

// ### tb/hul_host_model.sv
`timescale 1ns/1ps
// host microcontroller uart, send and receive tasks can run at the same time
module hul_host_model (
  // clock
  input wire logic i_clk,
  // serial lines
  input wire logic i_tx,
  output logic o_rx
);
  initial o_rx = 1'b1;
  task automatic send_byte(input logic [7:0] d, input int bc, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rx <= f[i];
      repeat (bc) @(posedge i_clk);
    end
    o_rx <= 1'b1;
  endtask : send_byte
  task automatic hold_low(input int n, input int gap);
    o_rx <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rx <= 1'b1;
    repeat (gap) @(posedge i_clk);
  endtask : hold_low
  task automatic get_byte(input int bc, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (i_tx !== 1'b0 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (bc / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge i_clk);
      d[i] = i_tx;
    end
    repeat (bc) @(posedge i_clk);
    ok = (n < 4000) && (i_tx === 1'b1);
  endtask : get_byte
endmodule : hul_host_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hul_pkg::*;
  // link reset length for simulation, well above a break at 1M
  localparam int RC = 3000;
  // stored default rate, not the reset value, so the load is seen
  localparam logic [1:0] OTP_CODE = BAUD_CODE_500K;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rx;
  logic tx;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_sof;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic frame_ok = 1'b0;
  logic resp_pending = 1'b0;
  logic sleep_mode = 1'b0;
  logic resp_abort;
  int err_count = 0;
  int samples_checked = 0;
  int n_val = 0;
  int n_sof = 0;
  int n_abt = 0;
  logic [7:0] last_rx = 8'h00;

  // 25 MHz clock
  always #20 clk = ~clk;

  hul_uart_link #(.RST_CYC(RC)) u_hul_uart_link (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_rx(rx), .o_tx(tx),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_sof(rx_sof),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_frame_ok(frame_ok), .i_resp_pending(resp_pending), .i_sleep_mode(sleep_mode),
    .i_otp_baud(OTP_CODE), .o_resp_abort(resp_abort)
  );

  hul_host_model u_hul_host_model (.i_clk(clk), .i_tx(tx), .o_rx(rx));

  // pulse counters on the stream side
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      n_val++;
      last_rx = rx_data;
    end
    if (rx_sof === 1'b1) n_sof++;
    if (resp_abort === 1'b1) n_abt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  // read data stands in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
    @(posedge clk);
  endtask : rd_chk

  // offers a byte and waits for the transmitter to take it
  task automatic take_tx(input logic [7:0] d, output int gap);
    gap = 0;
    tx_data <= d;
    tx_valid <= 1'b1;
    @(negedge clk);
    while (tx_ready !== 1'b1 && gap < 400) begin
      @(negedge clk);
      gap++;
    end
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask : take_tx

  task automatic t_reset;
    rd_chk(ADDR_LINK_STAT, {6'h00, OTP_CODE}, 8'h03);
    rd_chk(ADDR_LINK_CTRL, {6'h00, OTP_CODE}, 8'h03);
    rd_chk(ADDR_LINK_CTRL, 8'h04, 8'h0C);
    rd_chk(ADDR_HOLDOFF, HOLDOFF_RST, 8'hFF);
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00, 8'hFF);
  endtask : t_reset

  // every rate code, committed only by a good frame
  task automatic t_baud;
    logic [1:0] prev;
    int n0;
    prev = OTP_CODE;
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_LINK_CTRL, 8'h04 | 8'(c));
      rd_chk(ADDR_LINK_STAT, {6'h00, prev}, 8'h03);
      frame_ok <= 1'b1;
      @(posedge clk);
      frame_ok <= 1'b0;
      rd_chk(ADDR_LINK_STAT, 8'(c), 8'h03);
      prev = 2'(c);
      repeat (250) @(posedge clk);
      n0 = n_val;
      u_hul_host_model.send_byte(8'hA5 ^ 8'(c), 200 >> c, 1'b1);
      repeat (8) @(posedge clk);
      chk(8'(n_val - n0), 8'h01);
      chk(last_rx, 8'hA5 ^ 8'(c));
    end
  endtask : t_baud

  task automatic t_stop;
    int n0;
    n0 = n_val;
    u_hul_host_model.send_byte(8'h33, 25, 1'b0);
    repeat (8) @(posedge clk);
    chk(8'(n_val - n0), 8'h00);
    rd_chk(ADDR_SER_FAULT, 8'h01, 8'h07);
    wr_reg(ADDR_SER_FAULT, 8'h07);
    rd_chk(ADDR_SER_FAULT, 8'h00, 8'h07);
  endtask : t_stop

  // hold-off, then a reply with the host talking over it
  task automatic t_tx;
    int gap;
    int n0;
    logic [7:0] d;
    logic ok;
    wr_reg(ADDR_HOLDOFF, 8'h04);
    u_hul_host_model.send_byte(8'h11, 25, 1'b1);
    take_tx(8'hC3, gap);
    chk(8'(gap >= 85 && gap <= 230), 8'h01);
    n0 = n_val;
    fork
      u_hul_host_model.get_byte(25, d, ok);
      begin
        repeat (10) @(posedge clk);
        u_hul_host_model.send_byte(8'h00, 25, 1'b1);
      end
    join
    repeat (8) @(posedge clk);
    chk(8'(n_val - n0), 8'h00);
    chk(d, 8'hC3);
    chk({7'h00, ok}, 8'h01);
  endtask : t_tx

  // disable mid byte; receiver keeps working
  task automatic t_txoff;
    int gap;
    int lows;
    int n0;
    take_tx(8'hF0, gap);
    repeat (75) @(posedge clk);
    wr_reg(ADDR_LINK_CTRL, 8'h03);
    @(posedge clk);
    lows = 0;
    tx_valid <= 1'b1;
    repeat (200) begin
      @(posedge clk);
      if (tx !== 1'b1) lows++;
    end
    chk(8'(lows), 8'h00);
    @(negedge clk);
    chk({7'h00, tx_ready}, 8'h00);
    @(posedge clk);
    n0 = n_val;
    u_hul_host_model.send_byte(8'h96, 25, 1'b1);
    repeat (8) @(posedge clk);
    chk(8'(n_val - n0), 8'h01);
    chk(last_rx, 8'h96);
    tx_valid <= 1'b0;
    wr_reg(ADDR_LINK_CTRL, 8'h07);
  endtask : t_txoff

  // clear in daisy, shared bus and sleep conditions
  task automatic t_break;
    int s0;
    int a0;
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_SER_FAULT, 8'h07);
      wr_reg(ADDR_XFER_FAULT, 8'h03);
      wr_reg(ADDR_LINK_CTRL, (i == 1) ? 8'h0F : 8'h07);
      sleep_mode <= (i == 2);
      resp_pending <= 1'b1;
      s0 = n_sof;
      a0 = n_abt;
      u_hul_host_model.hold_low(13 * 25, 50);
      resp_pending <= 1'b0;
      sleep_mode <= 1'b0;
      rd_chk(ADDR_SER_FAULT, (i == 2) ? 8'h02 : 8'h03, 8'h07);
      rd_chk(ADDR_XFER_FAULT, 8'h01, 8'h03);
      chk(8'(n_sof - s0), 8'h01);
      chk(8'(n_abt - a0), 8'h01);
    end
    wr_reg(ADDR_LINK_CTRL, 8'h07);
  endtask : t_break

  // long low forces 250k, stored field kept
  task automatic t_rst;
    wr_reg(ADDR_SER_FAULT, 8'h07);
    wr_reg(ADDR_XFER_FAULT, 8'h03);
    resp_pending <= 1'b1;
    u_hul_host_model.hold_low(RC + 50, 300);
    resp_pending <= 1'b0;
    rd_chk(ADDR_SER_FAULT, 8'h07, 8'h07);
    rd_chk(ADDR_LINK_STAT, {6'h00, BAUD_CODE_250K}, 8'h03);
    rd_chk(ADDR_LINK_CTRL, {6'h00, BAUD_CODE_1M}, 8'h03);
    rd_chk(ADDR_XFER_FAULT, 8'h01, 8'h01);
    u_hul_host_model.send_byte(8'h69, 100, 1'b1);
    repeat (8) @(posedge clk);
    chk(last_rx, 8'h69);
  endtask : t_rst

  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_baud();
    t_stop();
    t_tx();
    t_txoff();
    t_break();
    t_rst();
    print_verdict();
  end

  // watchdog, well past the expected run
  initial begin
    #(60000 * 40);
    err_count++;
    print_verdict();
  end
endmodule : tb_top
